// File: rtl/ebcs_map.vh
// Constants for the external bus cycle sequencer.
// Operation
// R1 - Five phases in order: setup, delay, data, access, hold
// R2 - Phase lengths in timing units; delay 0-3, access 1-32
// R3 - Address setup 1-2 units, plus 0-3 on window change
// R4 - Write data setup or tristate phase 0-1 units
// R5 - Address and write data held 0-3 units
// R6 - Ready input may stretch access phase
// R7 - Read data captured as address advances, strobe rises
// R8 - Address change never corrupts captured read data
// R9 - Partner may drop read data after strobe rise
// R10 - Mux: 16 shared lines; demux: 24 address, 16 data
// R11 - Pin transitions at least 12.5 ns apart
// R12 - Ready polarity selectable; async ready adds a stage
// R13 - Ready inactive inserts wait; active ends cycle
// R14 - Chip select active from setup through hold
`ifndef EBCS_MAP_VH
`define EBCS_MAP_VH
`define EBCS_ST_IDLE      3'h0
`define EBCS_ST_SETUP     3'h1
`define EBCS_ST_CMD       3'h2
`define EBCS_ST_WDATA     3'h3
`define EBCS_ST_ACCESS    3'h4
`define EBCS_ST_HOLD      3'h5
`define EBCS_SYS_PERIOD_PS 100000
`define EBCS_MIN_EDGE_PS   12500
`define EBCS_MIN_EDGE_CYC  ((`EBCS_MIN_EDGE_PS + `EBCS_SYS_PERIOD_PS - 1) / `EBCS_SYS_PERIOD_PS)
`define EBCS_ADDR_W        24
`define EBCS_DATA_W        16
`define EBCS_CS_W          5
`define EBCS_CNT_W         5
`endif

// File: rtl/ebcs_sequencer.v
// External bus cycle sequencer: five-phase cycle engine with ready handshake.
`timescale 1ns/1ns
`include "ebcs_map.vh"
module ebcs_sequencer (
  input  wire                      i_clk_sys,         // System clock, 10 MHz.
  input  wire                      i_arst_n,          // Asynchronous reset, active low.
  input  wire [3:0]                i_unit_div,        // Timing unit length in system clocks minus one.
  input  wire                      i_req,             // Start a bus cycle while idle.
  input  wire                      i_req_write,       // Cycle is a write when high.
  input  wire [`EBCS_ADDR_W-1:0]   i_req_addr,        // Cycle address.
  input  wire [`EBCS_DATA_W-1:0]   i_req_wdata,       // Write data.
  input  wire                      i_req_upper,       // Upper byte access.
  input  wire [2:0]                i_req_cs,          // Chip select index.
  input  wire                      i_mux_mode,        // Multiplexed bus when high.
  input  wire [1:0]                i_addr_setup_len,  // Base setup length minus one (0..1).
  input  wire [1:0]                i_window_ext_len,  // Extra setup units on window change.
  input  wire [1:0]                i_cmd_delay_len,   // Command delay units.
  input  wire                      i_wdata_setup_len, // Data setup or tristate units.
  input  wire [4:0]                i_access_len,      // Access units minus one.
  input  wire [1:0]                i_hold_len,        // Hold units.
  input  wire                      i_ready_en,        // Ready handshake enable.
  input  wire                      i_ready_pol,       // Active level of ready.
  input  wire                      i_ready_async,     // Ready is asynchronous.
  input  wire                      i_ready_pin,       // Ready pin from partner.
  input  wire [`EBCS_DATA_W-1:0]   i_ad_in,           // Shared lines, input side.
  input  wire [`EBCS_DATA_W-1:0]   i_d_in,            // Demux data lines, input side.
  output reg  [`EBCS_DATA_W-1:0]   o_ad_out,          // Shared lines, driven value.
  output reg                       o_ad_oe,           // Shared lines drive enable.
  output reg  [`EBCS_DATA_W-1:0]   o_d_out,           // Demux data lines, driven value.
  output reg                       o_d_oe,            // Demux data drive enable.
  output reg  [`EBCS_ADDR_W-1:0]   o_addr,            // Demux address lines.
  output reg                       o_addr_latch,      // Address latch enable for mux mode.
  output reg                       o_rd_n,            // Read strobe, active low.
  output reg                       o_wr_n,            // Write strobe, active low.
  output reg                       o_upper_byte_strobe_n, // Upper byte strobe, active low.
  output reg  [`EBCS_CS_W-1:0]     o_cs_n,            // Chip selects, active low.
  output reg  [`EBCS_DATA_W-1:0]   o_rdata,           // Captured read data.
  output reg                       o_done,            // One-cycle pulse at cycle end.
  output reg                       o_busy,            // High while a cycle runs.
  output reg                       o_reference_clock_out // Timing unit reference clock.
);

  reg [2:0]                  state;       // Current phase.
  reg [2:0]                  next_state;  // Phase after the current unit.
  reg [3:0]                  div_cnt;     // Divider towards the unit tick.
  reg                        unit_tick;   // One-cycle pulse per timing unit.
  reg [`EBCS_CNT_W-1:0]      ph_cnt;      // Units left in the phase, minus one.
  reg [`EBCS_CNT_W-1:0]      next_cnt;    // Count loaded for the next phase.
  reg                        last_unit;   // Current unit ends the phase.
  reg [7:0]                  last_window; // Upper address of the previous cycle.
  reg                        win_chg;     // This cycle changes the window.
  reg                        cur_write;   // Latched cycle direction.
  reg [`EBCS_ADDR_W-1:0]     cur_addr;    // Latched address.
  reg [`EBCS_DATA_W-1:0]     cur_wdata;   // Latched write data.
  reg [2:0]                  rdy_sync;    // Three-stage pin synchroniser.
  reg                        rdy_async_q; // Extra stage for asynchronous ready.
  reg                        rdy_ext;     // Ready sample past access length.
  wire                       rdy_act;     // Ready active after polarity.
  wire                       rdy_use;     // Ready as seen by the sequencer.

  // Pin synchroniser: for asynchronous ready, a level counts once stages two and three agree; synchronous ready takes stage three.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdy_sync    <= 3'h0;
      rdy_async_q <= 1'b0;
    end else begin
      rdy_sync    <= {rdy_sync[1:0], i_ready_pin};
      if (rdy_sync[2] == rdy_sync[1]) begin
        rdy_async_q <= rdy_sync[2];
      end
    end
  end

  // The asynchronous choice reads one more stage, costing a waitstate. [R12]
  assign rdy_act = (i_ready_async ? rdy_async_q : rdy_sync[2]) ~^ i_ready_pol; // [R12]
  assign rdy_use = !i_ready_en || rdy_act;

  // Divider makes one unit tick every i_unit_div plus one clocks; a single clock already keeps pin edges apart. [R11]
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt   <= 4'h0;
      unit_tick <= 1'b0;
    end else if (div_cnt >= i_unit_div) begin
      div_cnt   <= 4'h0;
      unit_tick <= 1'b1;
    end else begin
      div_cnt   <= div_cnt + 4'h1;
      unit_tick <= 1'b0;
    end
  end

  // Next phase and its length, skipping zero-length phases in fixed order. [R1] [R2]
  always @* begin
    next_state = `EBCS_ST_IDLE;
    next_cnt   = 5'h00;
    case (state)
      `EBCS_ST_SETUP: begin
        if (i_cmd_delay_len != 2'h0) begin
          next_state = `EBCS_ST_CMD;
          next_cnt   = {3'h0, i_cmd_delay_len} - 5'h01; // [R2]
        end else if (i_wdata_setup_len) begin
          next_state = `EBCS_ST_WDATA; // [R4]
        end else begin
          next_state = `EBCS_ST_ACCESS;
          next_cnt   = i_access_len; // [R2]
        end
      end
      `EBCS_ST_CMD: begin
        if (i_wdata_setup_len) begin
          next_state = `EBCS_ST_WDATA; // [R4]
        end else begin
          next_state = `EBCS_ST_ACCESS;
          next_cnt   = i_access_len;
        end
      end
      `EBCS_ST_WDATA: begin
        next_state = `EBCS_ST_ACCESS;
        next_cnt   = i_access_len;
      end
      `EBCS_ST_ACCESS: begin
        if (i_hold_len != 2'h0) begin
          next_state = `EBCS_ST_HOLD; // [R5]
          next_cnt   = {3'h0, i_hold_len} - 5'h01;
        end
      end
      default: begin
        next_state = `EBCS_ST_IDLE;
        next_cnt   = 5'h00;
      end
    endcase
  end

  // Access ends only when its count ran out and ready is active or the handshake is disabled. [R6] [R13]
  always @* begin
    last_unit = (ph_cnt == 5'h00);
    if (state == `EBCS_ST_ACCESS) begin
      last_unit = (ph_cnt == 5'h00) && rdy_use; // [R13]
    end
  end

  // Main sequencer: phase state, counts and all pin registers.
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state                 <= `EBCS_ST_IDLE;
      ph_cnt                <= 5'h00;
      last_window           <= 8'h00;
      win_chg               <= 1'b0;
      cur_write             <= 1'b0;
      cur_addr              <= 24'h00_0000;
      cur_wdata             <= 16'h0000;
      rdy_ext               <= 1'b0;
      o_ad_out              <= 16'h0000;
      o_ad_oe               <= 1'b0;
      o_d_out               <= 16'h0000;
      o_d_oe                <= 1'b0;
      o_addr                <= 24'h00_0000;
      o_addr_latch          <= 1'b0;
      o_rd_n                <= 1'b1;
      o_wr_n                <= 1'b1;
      o_upper_byte_strobe_n <= 1'b1;
      o_cs_n                <= 5'h1f;
      o_rdata               <= 16'h0000;
      o_done                <= 1'b0;
      o_busy                <= 1'b0;
      o_reference_clock_out <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (unit_tick) begin
        o_reference_clock_out <= ~o_reference_clock_out;
      end
      if (state == `EBCS_ST_IDLE) begin
        if (i_req && unit_tick) begin
          // Start: latch request, drive address and select for the setup phase. [R1] [R14]
          state       <= `EBCS_ST_SETUP;
          win_chg     <= (i_req_addr[23:16] != last_window);
          // Setup lasts the base length plus the window extension if the window moves. [R3]
          ph_cnt      <= (i_req_addr[23:16] != last_window) ?
                         ({4'h0, i_addr_setup_len[0]} + {3'h0, i_window_ext_len}) : {4'h0, i_addr_setup_len[0]};
          last_window <= i_req_addr[23:16];
          cur_write   <= i_req_write;
          cur_addr    <= i_req_addr;
          cur_wdata   <= i_req_wdata;
          o_busy      <= 1'b1;
          o_addr      <= i_req_addr; // [R10]
          o_cs_n      <= ~(5'h01 << i_req_cs); // [R14]
          o_upper_byte_strobe_n <= ~i_req_upper;
          o_addr_latch <= i_mux_mode;
          o_ad_out    <= i_req_addr[15:0]; // [R10]
          o_ad_oe     <= i_mux_mode;
        end
      end else if (unit_tick) begin
        if (state == `EBCS_ST_ACCESS) begin
          rdy_ext <= (ph_cnt == 5'h00) && !rdy_use; // Waitstate past programmed length. [R6]
        end
        if (!last_unit) begin
          if (ph_cnt != 5'h00) begin
            ph_cnt <= ph_cnt - 5'h01;
          end
        end else begin
          state  <= next_state;
          ph_cnt <= next_cnt;
          if (state == `EBCS_ST_SETUP) begin
            o_addr_latch <= 1'b0;
          end
          if (next_state == `EBCS_ST_WDATA || next_state == `EBCS_ST_ACCESS) begin
            if (state == `EBCS_ST_SETUP || state == `EBCS_ST_CMD) begin
              // Lines switch to write data, or release for the read data. [R4] [R10]
              o_ad_out <= cur_wdata;
              o_ad_oe  <= i_mux_mode && cur_write;
              o_d_out  <= cur_wdata;
              o_d_oe   <= !i_mux_mode && cur_write;
            end
          end
          if (next_state == `EBCS_ST_ACCESS) begin
            o_rd_n <= cur_write;
            o_wr_n <= !cur_write;
          end
          if (state == `EBCS_ST_ACCESS) begin
            // Strobe rises and read data is caught on this same edge. [R7] [R9]
            o_rd_n <= 1'b1;
            o_wr_n <= 1'b1;
            if (!cur_write) begin
              o_rdata <= i_mux_mode ? i_ad_in : i_d_in; // [R7] [R8]
            end
          end
          if (next_state == `EBCS_ST_IDLE) begin
            // End of hold, or of access without hold: release select, byte strobe and lines; address keeps its value. [R5] [R14]
            o_cs_n                <= 5'h1f;
            o_upper_byte_strobe_n <= 1'b1;
            o_ad_oe               <= 1'b0;
            o_d_oe                <= 1'b0;
            o_busy                <= 1'b0;
            o_done                <= 1'b1;
            rdy_ext               <= 1'b0;
          end
        end
      end
    end
  end

endmodule

// File: tb/ebcs_mem_model.sv
// Memory partner that answers the sequencer's bus cycles.
`timescale 1ns/1ns
module ebcs_mem_model (
  input  wire        i_clk_sys,
  input  wire        i_mux_mode,
  input  wire        i_ready_pol,
  input  wire [3:0]  i_rdy_wait,
  input  wire        i_rd_n,
  input  wire        i_wr_n,
  input  wire        i_ale,
  input  wire [15:0] i_ad_out,
  input  wire [15:0] i_d_out,
  input  wire [23:0] i_addr,
  output wire [15:0] o_ad_in,
  output wire [15:0] o_d_in,
  output wire        o_ready_pin
);
  reg  [15:0] mem [0:15];
  reg  [15:0] last = 16'h0000;
  reg  [3:0]  idx = 4'h0;
  reg  [3:0]  wcnt = 4'h0;
  wire [3:0]  cur = i_mux_mode ? idx : i_addr[3:0];
  wire        strobe = !i_rd_n || !i_wr_n;
  integer     k;
  initial for (k = 0; k < 16; k = k + 1) mem[k] = {4{k[3:0]}};
  // Latch the word index, age the strobe and store written words.
  always @(posedge i_clk_sys) begin
    if (i_ale) idx <= i_ad_out[3:0];
    wcnt <= strobe ? wcnt + {3'h0, ~&wcnt} : 4'h0;
    if (!i_wr_n) mem[cur] <= i_mux_mode ? i_ad_out : i_d_out;
    last <= i_rd_n ? last : mem[cur];
  end
  // Read data is valid only while the read strobe is low; it flips afterwards.
  assign o_ad_in = i_rd_n ? ~last : mem[cur];
  assign o_d_in = o_ad_in;
  // Ready turns active after the chosen wait, at the chosen level.
  assign o_ready_pin = (strobe && wcnt >= i_rdy_wait) ? i_ready_pol : ~i_ready_pol;
endmodule

// File: tb/ebcs_seq_sva.sv
// Checker for the bus cycle sequencer port behaviour.
`timescale 1ns/1ns
`include "ebcs_map.vh"
module ebcs_seq_sva (
  input wire                    i_clk_sys,
  input wire                    i_arst_n,
  input wire                    o_rd_n,
  input wire                    o_wr_n,
  input wire                    o_addr_latch,
  input wire                    o_ad_oe,
  input wire                    o_d_oe,
  input wire                    o_busy,
  input wire                    o_done,
  input wire [`EBCS_CS_W-1:0]   o_cs_n,
  input wire [`EBCS_ADDR_W-1:0] o_addr,
  input wire [`EBCS_DATA_W-1:0] o_d_out,
  input wire [`EBCS_DATA_W-1:0] o_rdata
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // Steps of a cycle: start, strobe, start of read strobe.
  sequence s_start; $rose(o_busy); endsequence
  sequence s_strobe; !o_rd_n || !o_wr_n; endsequence
  sequence s_rd_fall; $fell(o_rd_n); endsequence
  a_cs_single: assert property ($onehot0(~o_cs_n)) else $error("two chip selects low");
  a_strobe_cs: assert property (s_strobe |-> o_busy && $onehot(~o_cs_n)) else $error("strobe without select");
  a_idle_cs: assert property (!o_busy |-> &o_cs_n) else $error("select low while idle");
  a_strobe_excl: assert property (!(!o_rd_n && !o_wr_n)) else $error("both strobes low");
  a_ale_phase: assert property (o_addr_latch |-> o_rd_n && o_wr_n) else $error("latch during access");
  a_read_release: assert property (!o_rd_n |-> !o_ad_oe && !o_d_oe) else $error("lines driven in read");
  a_addr_hold: assert property (o_busy && $past(o_busy) |-> $stable(o_addr)) else $error("address moved");
  a_wdata_hold: assert property (!o_wr_n && $past(!o_wr_n) |-> $stable(o_d_out)) else $error("wdata moved");
  a_rdata_edge: assert property ($changed(o_rdata) |-> $rose(o_rd_n)) else $error("rdata off edge");
  a_access_min: assert property (s_rd_fall |=> !o_rd_n) else $error("access too short");
  a_done_pulse: assert property (o_done |-> &o_cs_n ##1 !o_done) else $error("done not a pulse");
  a_cycle_bound: assert property (s_start |-> ##[1:1000] o_done) else $error("cycle never ends");
endmodule
bind ebcs_sequencer ebcs_seq_sva chk (.*);

// File: tb/test_ebcs_sequencer.sv
// Self-checking bench for the bus cycle sequencer.
`timescale 1ns/1ns
`include "ebcs_map.vh"
module test_ebcs_sequencer;
  typedef struct packed {logic wr, up, mux, rdy; logic [2:0] cs; logic [8:0] acc;
    logic [23:0] addr; logic [15:0] data;} ebcs_note_t;
  reg        i_clk_sys = 1'b0, i_arst_n = 1'b0, i_req = 1'b0, i_req_write = 1'b0, i_req_upper = 1'b0;
  reg        i_mux_mode = 1'b0, i_wdata_setup_len = 1'b0, i_ready_en = 1'b0, i_ready_pol = 1'b0;
  reg        i_ready_async = 1'b0;
  reg [3:0]  i_unit_div = 4'h1, rdy_wait = 4'h0;
  reg [23:0] i_req_addr = 24'h00_0000;
  reg [15:0] i_req_wdata = 16'h0000;
  reg [2:0]  i_req_cs = 3'h0;
  reg [1:0]  i_addr_setup_len = 2'h0, i_window_ext_len = 2'h0, i_cmd_delay_len = 2'h0, i_hold_len = 2'h0;
  reg [4:0]  i_access_len = 5'h00;
  wire [15:0] i_ad_in, i_d_in, o_ad_out, o_d_out, o_rdata;
  wire [23:0] o_addr;
  wire [4:0]  o_cs_n;
  wire        i_ready_pin, o_ad_oe, o_d_oe, o_addr_latch, o_rd_n, o_wr_n, o_upper_byte_strobe_n;
  wire        o_done, o_busy, o_reference_clock_out;
  reg [31:0]  seed = 32'h4045_2bed;
  reg [15:0]  shadow [0:15];
  reg [15:0]  s_ale, s_wm, s_wd;
  reg [23:0]  s_addr;
  reg [4:0]   s_cs;
  reg [8:0]   s_cnt = 9'h000;
  reg         s_up;
  ebcs_note_t notes[$];
  integer     errors = 0, checks = 0, k;
  ebcs_sequencer uut (.*);
  ebcs_mem_model mem (.i_clk_sys(i_clk_sys), .i_mux_mode(i_mux_mode), .i_ready_pol(i_ready_pol),
    .i_rdy_wait(rdy_wait), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_ale(o_addr_latch), .i_ad_out(o_ad_out),
    .i_d_out(o_d_out), .i_addr(o_addr), .o_ad_in(i_ad_in), .o_d_in(i_d_in), .o_ready_pin(i_ready_pin));
  initial forever #50 i_clk_sys = ~i_clk_sys;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks = checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watch the pins; at each done, take the oldest note and compare.
  always @(negedge i_clk_sys) begin : mon
    ebcs_note_t n;
    if (o_addr_latch) s_ale = o_ad_out;
    if (!o_rd_n || !o_wr_n) begin
      s_cnt = s_cnt + 9'h001;
      {s_cs, s_up, s_addr, s_wm, s_wd} = {o_cs_n, o_upper_byte_strobe_n, o_addr, o_ad_out, o_d_out};
    end
    if (o_done) begin
      n = notes.pop_front();
      cmp("cs_n", {19'h0_0000, ~(5'h01 << n.cs)}, 24'(s_cs));
      cmp("ubs_n", {23'h00_0000, ~n.up}, 24'(s_up));
      cmp("addr", n.mux ? 24'(n.addr[15:0]) : n.addr, n.mux ? 24'(s_ale) : s_addr);
      if (n.rdy) cmp("stretch", 24'h00_0001, 24'(s_cnt >= n.acc));
      else cmp("access", 24'(n.acc), 24'(s_cnt));
      if (n.wr) cmp("wdata", 24'(n.data), 24'(n.mux ? s_wm : s_wd));
      else cmp("rdata", 24'(n.data), 24'(o_rdata));
      s_cnt = 9'h000;
    end
  end
  // One random bus cycle: note the expectation, request, wait for done.
  task automatic run();
    ebcs_note_t n;
    logic [31:0] r, q;
    integer t;
    r = rnd();
    q = rnd();
    @(posedge i_clk_sys);
    {n.wr, n.up, n.mux, n.rdy} = {q[13], r[5], r[9], q[6]};
    n.cs = {1'b0, r[7:6]} + {2'b00, r[8]};
    n.addr = {7'h00, r[4], 12'h000, r[3:0]};
    n.acc = (q[3] ? 9'h020 : 9'h001 + q[2:0]) * (q[5] ? 9'h004 : 9'h002);
    n.data = n.wr ? r[31:16] : shadow[r[3:0]];
    if (n.wr) shadow[r[3:0]] = r[31:16];
    notes.push_back(n);
    {i_req, i_req_write, i_req_addr, i_req_wdata} <= {1'b1, n.wr, n.addr, r[31:16]};
    {i_req_upper, i_req_cs, i_mux_mode, rdy_wait} <= {n.up, n.cs, n.mux, q[12:9]};
    i_unit_div <= q[5] ? 4'h3 : 4'h1;
    i_access_len <= q[3] ? 5'h1f : {2'h0, q[2:0]};
    {i_addr_setup_len, i_window_ext_len, i_cmd_delay_len, i_hold_len} <= q[31:24];
    {i_wdata_setup_len, i_ready_en, i_ready_pol, i_ready_async} <= {q[14], n.rdy, q[7], q[8]};
    for (t = 0; t < 64 && o_busy !== 1'b1; t++) @(negedge i_clk_sys);
    if (t == 64) begin
      errors = errors + 1;
      tally_and_finish();
    end
    @(posedge i_clk_sys);
    i_req <= 1'b0;
    for (t = 0; t < 2000 && o_done !== 1'b1; t++) @(negedge i_clk_sys);
    if (t == 2000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  endtask
  initial begin
    for (k = 0; k < 16; k++) shadow[k] = {4{k[3:0]}};
    repeat (16) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (80) run();
    tally_and_finish();
  end
endmodule
